// ===== rtl/mdc_pkg.sv
// Package for the multiplexed dynamic memory controller.
// Assumes a single 200 MHz core clock; all times are converted to cycles here.
package mdc_pkg;

   // Clock period in picoseconds.
   localparam int unsigned CLK_PERIOD_PS = 5000;

   // Address geometry.
   localparam int unsigned ADDR_W     = 14;
   localparam int unsigned HALF_W     = 7;
   localparam int unsigned ROW_COUNT  = 128;

   // Pin timings in nanoseconds, fastest grade.
   localparam int unsigned ROW_ADDRESS_HOLD_NS      = 20;
   localparam int unsigned ROW_ACCESS_TIME_NS       = 150;
   localparam int unsigned COLUMN_ACCESS_TIME_NS    = 100;
   localparam int unsigned OUTPUT_TURNOFF_DELAY_NS  = 40;
   localparam int unsigned WRITE_DATA_HOLD_NS       = 45;
   localparam int unsigned ROW_TO_WRITE_DELAY_NS    = 120;
   localparam int unsigned COLUMN_TO_WRITE_DELAY_NS = 70;
   localparam int unsigned ROW_PRECHARGE_TIME_NS    = 100;
   localparam int unsigned RANDOM_CYCLE_TIME_NS     = 320;
   localparam int unsigned ROW_STROBE_PULSE_WIDTH_NS = 150;
   localparam int unsigned REFRESH_INTERVAL_MS      = 2;
   localparam int unsigned INIT_CYCLES              = 8;
   // Flip-flops the data output passes before logic reads it.
   localparam int unsigned SYNC_STAGES              = 2;

   // Least times round up to whole cycles.
   function automatic int unsigned ns_to_cyc(input int unsigned ns);
      int unsigned c;
      c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
      return (c == 0) ? 1 : c;
   endfunction

   localparam int unsigned RAH_CYC  = ns_to_cyc(ROW_ADDRESS_HOLD_NS);
   localparam int unsigned RAC_CYC  = ns_to_cyc(ROW_ACCESS_TIME_NS);
   localparam int unsigned CAC_CYC  = ns_to_cyc(COLUMN_ACCESS_TIME_NS);
   localparam int unsigned OFF_CYC  = ns_to_cyc(OUTPUT_TURNOFF_DELAY_NS);
   localparam int unsigned DH_CYC   = ns_to_cyc(WRITE_DATA_HOLD_NS);
   localparam int unsigned RWD_CYC  = ns_to_cyc(ROW_TO_WRITE_DELAY_NS);
   localparam int unsigned CWD_CYC  = ns_to_cyc(COLUMN_TO_WRITE_DELAY_NS);
   localparam int unsigned RP_CYC   = ns_to_cyc(ROW_PRECHARGE_TIME_NS);
   localparam int unsigned RC_CYC   = ns_to_cyc(RANDOM_CYCLE_TIME_NS);
   localparam int unsigned RAS_CYC  = ns_to_cyc(ROW_STROBE_PULSE_WIDTH_NS);
   // Longest time rounds down: interval split over all rows.
   localparam int unsigned REF_SPACING_CYC =
      (REFRESH_INTERVAL_MS * 1000000 / CLK_PERIOD_PS * 1000) / ROW_COUNT;

   localparam int unsigned CNT_W = 16;

   // Operations the user may request.
   typedef enum logic [1:0] {
      MDC_OP_READ  = 2'h0,
      MDC_OP_WRITE = 2'h1,
      MDC_OP_RMW   = 2'h2
   } mdc_op_t;

   // One user request.
   typedef struct packed {
      mdc_op_t             op;
      logic [ADDR_W-1:0]   addr;
      logic                wdata;
   } mdc_req_t;

   // Strobe and address pins toward the memory, all active low strobes.
   typedef struct packed {
      logic                ras_n;
      logic                cas_n;
      logic                we_n;
      logic [HALF_W-1:0]   addr;
      logic                din;
   } mdc_pins_t;

endpackage

// ===== rtl/mdc_ctrl.sv
// Controller that drives a 16k x 1 multiplexed dynamic memory through its pins.
// Assumes the memory's data output arrives asynchronously and is synchronised here.
`timescale 1ns/1ps

// What this block does
// - Send 14-bit address as row then column
// - Hold row address before column strobe falls
// - Never sample output in undefined write positions
// - One access per row opening keeps row strobe under its maximum low time
// - Precharge and random cycle time between cycles
// - Visit all 128 rows each refresh interval
// - Refresh cycles pulse row strobe only
// - Eight row-strobe cycles after power-up first
module mdc_ctrl #(
   parameter int unsigned REF_SPACING = mdc_pkg::REF_SPACING_CYC
) (
   // Clock, reset and enable.
   input  wire logic               core_clk,
   input  wire logic               resetn,
   input  wire logic               clk_en,
   // User request side.
   input  wire logic               req_valid,
   output logic                    req_ready,
   input  wire mdc_pkg::mdc_req_t  req,
   // User answer side.
   output logic                    rsp_valid,
   output logic                    rsp_rdata,
   output logic                    init_done,
   // Memory pins.
   output mdc_pkg::mdc_pins_t      mem,
   input  wire logic               mem_dout
);
   import mdc_pkg::*;

   typedef enum {
      ST_RESET, ST_IDLE, ST_ROW, ST_COL, ST_WAIT, ST_WRITE, ST_END, ST_PRE
   } mdc_state_t;

   mdc_state_t          state_q, state_d;
   logic [CNT_W-1:0]    cnt_q, cnt_d;
   logic [CNT_W-1:0]    ref_cnt_q, ref_cnt_d;
   logic [CNT_W-1:0]    cyc_cnt_q, cyc_cnt_d;
   logic [HALF_W-1:0]   ref_row_q, ref_row_d;
   logic [3:0]          init_q, init_d;
   logic                ref_pend_q, ref_pend_d;
   logic                is_ref_q, is_ref_d;
   mdc_req_t            cur_q, cur_d;
   mdc_pins_t           pins_q, pins_d;
   logic                rsp_valid_q, rsp_valid_d;
   logic                rdata_q, rdata_d;
   logic                dout_s1_q, dout_s2_q;

   // Row and column halves of the stored address.
   function automatic logic [HALF_W-1:0] row_of(input logic [ADDR_W-1:0] a);
      return a[ADDR_W-1:HALF_W];
   endfunction
   function automatic logic [HALF_W-1:0] col_of(input logic [ADDR_W-1:0] a);
      return a[HALF_W-1:0];
   endfunction

   // Data output passes two flip-flops before anything reads it.
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         dout_s1_q <= 1'b0;
         dout_s2_q <= 1'b0;
      end else if (clk_en) begin
         dout_s1_q <= mem_dout;
         dout_s2_q <= dout_s1_q;
      end
   end

   // Next-state logic for the strobe sequencer.
   always_comb begin
      state_d     = state_q;
      cnt_d       = cnt_q + CNT_W'(1);
      cyc_cnt_d   = cyc_cnt_q + CNT_W'(1);
      ref_cnt_d   = ref_cnt_q + CNT_W'(1);
      ref_row_d   = ref_row_q;
      init_d      = init_q;
      ref_pend_d  = ref_pend_q;
      is_ref_d    = is_ref_q;
      cur_d       = cur_q;
      pins_d      = pins_q;
      rsp_valid_d = 1'b0;
      rdata_d     = rdata_q;
      // Periodic refresh request; the set wins over the clear below.
      if (ref_cnt_q >= CNT_W'(REF_SPACING - 1)) begin
         ref_cnt_d  = '0;
         ref_pend_d = 1'b1;
      end
      case (state_q)
         ST_RESET: begin
            // Power-up row-strobe-only cycles before any access.
            is_ref_d = 1'b1;
            cnt_d    = '0;
            cyc_cnt_d = '0; // Random cycle time counts from this row fall.
            state_d  = ST_ROW;
            pins_d.addr  = ref_row_q;
            pins_d.ras_n = 1'b0;
         end
         ST_IDLE: begin
            pins_d.ras_n = 1'b1; // Standby while row strobe is high.
            pins_d.cas_n = 1'b1;
            pins_d.we_n  = 1'b1;
            if (ref_pend_q) begin
               // Refresh: column strobe stays high, row address applied.
               is_ref_d     = 1'b1;
               ref_pend_d   = (ref_cnt_q >= CNT_W'(REF_SPACING - 1));
               pins_d.addr  = ref_row_q;
               pins_d.ras_n = 1'b0;
               cnt_d        = '0;
               cyc_cnt_d    = '0;
               state_d      = ST_ROW;
            end else if (req_valid) begin
               // Row half goes out first with the row strobe.
               is_ref_d     = 1'b0;
               cur_d        = req;
               pins_d.addr  = row_of(req.addr);
               pins_d.ras_n = 1'b0;
               pins_d.din   = req.wdata;
               // Early write: write strobe low for whole access.
               pins_d.we_n  = (req.op != MDC_OP_WRITE);
               cnt_d        = '0;
               cyc_cnt_d    = '0;
               state_d      = ST_ROW;
            end
         end
         ST_ROW: begin
            if (is_ref_q) begin
               // Row strobe held for its least pulse width.
               if (cnt_q >= CNT_W'(RAS_CYC - 1)) begin
                  pins_d.ras_n = 1'b1;
                  ref_row_d    = ref_row_q + HALF_W'(1);
                  if (init_q < 4'(INIT_CYCLES))
                     init_d = init_q + 4'h1;
                  cnt_d   = '0;
                  state_d = ST_PRE;
               end
            end else if (cnt_q >= CNT_W'(RAH_CYC - 1)) begin
               // Column half after the row address hold.
               pins_d.addr  = col_of(cur_q.addr);
               pins_d.cas_n = 1'b0;
               cnt_d        = '0;
               state_d      = ST_COL;
            end
         end
         ST_COL: begin
            // Wait the access time from both strobes before sampling.
            // Extra cycles cover the input synchroniser.
            if (cnt_q >= CNT_W'(CAC_CYC + SYNC_STAGES) &&
                cyc_cnt_q >= CNT_W'(RAC_CYC + SYNC_STAGES)) begin
               if (cur_q.op != MDC_OP_WRITE)
                  rdata_d = dout_s2_q; // Sampled while column strobe low.
               cnt_d = '0;
               state_d = (cur_q.op == MDC_OP_RMW) ? ST_WAIT : ST_END;
            end
         end
         ST_WAIT: begin
            // Read/write: write strobe falls after both write delays.
            // The column strobe fell when the cycle count stood at the row hold.
            if (cyc_cnt_q >= CNT_W'(RWD_CYC) &&
                cyc_cnt_q >= CNT_W'(RAH_CYC + CWD_CYC)) begin
               pins_d.we_n = 1'b0;
               cnt_d       = '0;
               state_d     = ST_WRITE;
            end
         end
         ST_WRITE: begin
            // Data and write strobe held past capture edge.
            if (cnt_q >= CNT_W'(DH_CYC)) begin
               cnt_d   = '0;
               state_d = ST_END;
            end
         end
         ST_END: begin
            // Meet row strobe width, write hold, then raise all three strobes.
            if (cyc_cnt_q >= CNT_W'(RAS_CYC) && cnt_q >= CNT_W'(DH_CYC)) begin
               pins_d.ras_n = 1'b1;
               pins_d.cas_n = 1'b1;
               pins_d.we_n  = 1'b1;
               rsp_valid_d  = 1'b1;
               cnt_d        = '0;
               state_d      = ST_PRE;
            end
         end
         ST_PRE: begin
            // Precharge and random cycle time; output off time is covered.
            if (cnt_q >= CNT_W'(RP_CYC - 1) && cyc_cnt_q >= CNT_W'(RC_CYC - 1))
               state_d = (init_q < 4'(INIT_CYCLES)) ? ST_RESET : ST_IDLE;
         end
         default: state_d = ST_IDLE;
      endcase
   end

   // Registers for the sequencer; each access opens one row, refreshing it.
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         state_q     <= ST_RESET;
         cnt_q       <= '0;
         cyc_cnt_q   <= '0;
         ref_cnt_q   <= '0;
         ref_row_q   <= '0;
         init_q      <= '0;
         ref_pend_q  <= 1'b0;
         is_ref_q    <= 1'b0;
         cur_q       <= '0;
         pins_q      <= '{ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, addr: '0, din: 1'b0};
         rsp_valid_q <= 1'b0;
         rdata_q     <= 1'b0;
      end else if (clk_en) begin
         state_q     <= state_d;
         cnt_q       <= cnt_d;
         cyc_cnt_q   <= cyc_cnt_d;
         ref_cnt_q   <= ref_cnt_d;
         ref_row_q   <= ref_row_d;
         init_q      <= init_d;
         ref_pend_q  <= ref_pend_d;
         is_ref_q    <= is_ref_d;
         cur_q       <= cur_d;
         pins_q      <= pins_d;
         rsp_valid_q <= rsp_valid_d;
         rdata_q     <= rdata_d;
      end
   end

   // Outputs; one page per access, so page time limits are never approached.
   assign req_ready = (state_q == ST_IDLE) && !ref_pend_q && clk_en;
   assign rsp_valid = rsp_valid_q;
   assign rsp_rdata = rdata_q;
   assign init_done = (init_q >= 4'(INIT_CYCLES));
   assign mem       = pins_q;

endmodule

// ===== verification/mdc_ctrl_assertions.sv
// Checker on the controller's memory pins and request side.
// Assumes it is bound onto mdc_ctrl and sees only that module's ports.
`timescale 1ns/1ps
module mdc_ctrl_assertions #(
   parameter int unsigned REF_SPACING = 200
) (
   // Clock and reset.
   input wire logic               core_clk,
   input wire logic               resetn,
   // Request side.
   input wire logic               req_ready,
   input wire logic               init_done,
   // Memory pins.
   input wire mdc_pkg::mdc_pins_t mem
);
   import mdc_pkg::*;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!resetn);
   // Cycles since the last row strobe rise and fall, and falls since reset.
   logic [11:0] hi_q;
   logic [11:0] lo_q;
   logic [3:0]  falls_q;
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         hi_q    <= 12'hFFF;
         lo_q    <= 12'hFFF;
         falls_q <= 4'h0;
      end else begin
         hi_q    <= $rose(mem.ras_n) ? 12'h001 : hi_q + 12'(hi_q != 12'hFFF);
         lo_q    <= $fell(mem.ras_n) ? 12'h001 : lo_q + 12'(lo_q != 12'hFFF);
         falls_q <= falls_q + 4'($fell(mem.ras_n) && falls_q != 4'hF);
      end
   end
   AST_CAS_IN_ROW: assert property ($fell(mem.cas_n) |-> !mem.ras_n)
      else $error("column strobe fell with no open row");
   AST_ROW_HOLD: assert property ($fell(mem.cas_n) |-> $past(mem.ras_n, 4) == 1'b0)
      else $error("column strobe fell too soon after row strobe");
   AST_PRECHARGE: assert property ($fell(mem.ras_n) |-> hi_q >= 12'h014)
      else $error("row strobe precharge too short");
   AST_CYCLE_TIME: assert property ($fell(mem.ras_n) |-> lo_q >= 12'h040)
      else $error("random cycle time too short");
   AST_RAS_MAX_LOW: assert property (!mem.ras_n && !$fell(mem.ras_n) |-> lo_q < 12'h7D0)
      else $error("row strobe low too long");
   AST_EARLY_WRITE: assert property (
      $fell(mem.cas_n) && !mem.we_n |-> $past(mem.we_n, 4) == 1'b0)
      else $error("early write strobe set up too late");
   AST_LATE_WRITE: assert property (
      $fell(mem.we_n) && !mem.cas_n |-> $past(mem.cas_n, 14) == 1'b0 && $past(mem.ras_n, 24) == 1'b0)
      else $error("write strobe fell in the undefined window");
   AST_DIN_HOLD: assert property (
      ($fell(mem.cas_n) && !mem.we_n) || ($fell(mem.we_n) && !mem.cas_n) |=> $stable(mem.din)[*8])
      else $error("write data not held after capture");
   AST_READY_AFTER_INIT: assert property (req_ready |-> init_done && mem.ras_n)
      else $error("request taken before init or with a row open");
   AST_INIT_COUNT: assert property ($rose(init_done) |-> falls_q >= 4'h8)
      else $error("init finished with too few row strobe cycles");
   AST_REFRESH_GAP: assert property (
      $fell(mem.ras_n) && falls_q != 4'h0 |-> lo_q < 12'(REF_SPACING + 3 * RC_CYC))
      else $error("row strobe idle too long for refresh");
endmodule

// ===== verification/mdc_dram_model.sv
// Behavioural 16k x 1 dynamic memory driven by the controller's pins.
// Assumes one access per row opening; times are those of the fastest grade.
`timescale 1ns/1ps
module mdc_dram_model (
   // Strobes, address and write data.
   input  wire mdc_pkg::mdc_pins_t mem,
   // Read data; shows the inverse of its last value while off.
   output logic                    dout
);
   import mdc_pkg::*;
   logic       cells [0:16383];
   logic [6:0] row_q;
   logic [6:0] col_q;
   logic       bit_q;
   realtime    t_row;
   initial dout = 1'b0;
   // Row fall latches and so refreshes the row; row high means standby.
   always @(negedge mem.ras_n) begin
      row_q = mem.addr;
      t_row = $realtime;
   end
   // Column fall: an early write stores now and leaves the output off.
   always @(negedge mem.cas_n) begin
      col_q = mem.addr;
      bit_q = cells[{row_q, col_q}];
      if (!mem.we_n) cells[{row_q, col_q}] = mem.din;
      else begin
         #(t_row + 150.0 - $realtime > 100.0 ? t_row + 150.0 - $realtime : 100.0);
         if (!mem.cas_n) dout = bit_q;
      end
   end
   // Late write strobe with the column open stores after the read.
   always @(negedge mem.we_n) begin
      if (!mem.cas_n) cells[{row_q, col_q}] = mem.din;
   end
   // Column rise turns the output off after the turn-off delay.
   always @(posedge mem.cas_n) begin
      #40 dout = ~dout;
   end
endmodule

// ===== verification/mdc_ctrl_test.sv
// Self-checking bench for the dynamic memory controller.
// Assumes the behavioural memory model and a shortened refresh spacing.
`timescale 1ns/1ps
module mdc_ctrl_test;
   import mdc_pkg::*;
   localparam int unsigned SPACING = 200;
   logic         core_clk  = 1'b0;
   logic         resetn    = 1'b0;
   logic         clk_en    = 1'b1;
   logic         req_valid = 1'b0;
   mdc_req_t     req       = '0;
   logic         req_ready;
   logic         rsp_valid;
   logic         rsp_rdata;
   logic         init_done;
   mdc_pins_t    mem;
   logic         mem_dout;
   logic [6:0]   row_seen;
   logic [6:0]   col_seen;
   logic [127:0] rows_hit;
   int           ras_falls, cas_falls, cycles, bad_count, checks_done;
   mdc_ctrl #(.REF_SPACING(SPACING)) dut (
      .core_clk  (core_clk),
      .resetn    (resetn),
      .clk_en    (clk_en),
      .req_valid (req_valid),
      .req_ready (req_ready),
      .req       (req),
      .rsp_valid (rsp_valid),
      .rsp_rdata (rsp_rdata),
      .init_done (init_done),
      .mem       (mem),
      .mem_dout  (mem_dout)
   );
   mdc_dram_model model (.mem(mem), .dout(mem_dout));
   // Halves and rows as they appear on the pins.
   always @(negedge mem.ras_n) begin
      row_seen = mem.addr;
      rows_hit[mem.addr] = 1'b1;
      ras_falls++;
   end
   always @(negedge mem.cas_n) begin
      col_seen = mem.addr;
      cas_falls++;
   end
   // Clock and hang guard.
   always #2.5 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 40000) begin
         bad_count++;
         test_done();
      end
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic test_done();
      $display("Checks made %0d, mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // One request held until taken, then its answer awaited.
   task automatic access(input mdc_op_t op, input logic [13:0] a, input logic d,
                         output logic q);
      int n;
      n = 0;
      @(posedge core_clk);
      req_valid <= 1'b1;
      req <= '{op: op, addr: a, wdata: d};
      do @(negedge core_clk); while (req_ready !== 1'b1 && ++n < 1000);
      @(posedge core_clk);
      req_valid <= 1'b0;
      do @(negedge core_clk); while (rsp_valid !== 1'b1 && ++n < 2000);
      check(rsp_valid, 1'b1);
      q = rsp_rdata;
   endtask
   task automatic t_init();
      int n;
      n = 0;
      while (init_done !== 1'b1 && n < 2000) begin
         @(negedge core_clk);
         n++;
      end
      check(16'(init_done), 16'h1);
      check(16'(ras_falls >= 8), 16'h1);
   endtask
   // Enable low freezes the controller: no row opens, then a read still works.
   task automatic t_freeze();
      int f;
      logic q;
      f = ras_falls;
      @(posedge core_clk);
      clk_en <= 1'b0;
      repeat (20) @(negedge core_clk);
      check(16'(req_ready), 16'h0);
      check(16'(ras_falls - f), 16'h0);
      @(posedge core_clk);
      clk_en <= 1'b1;
      access(MDC_OP_READ, 14'h1580, 1'b0, q);
      check(q, 1'b1);
   endtask
   // Early writes to corner addresses, then reads back with split checked.
   task automatic t_write_read();
      logic [13:0] addrs [4] = '{14'h0000, 14'h3FFF, 14'h2A55, 14'h1580};
      logic q;
      foreach (addrs[i]) access(MDC_OP_WRITE, addrs[i], i[0], q);
      foreach (addrs[i]) begin
         access(MDC_OP_READ, addrs[i], 1'b0, q);
         check(q, i[0]);
         check({row_seen, col_seen}, addrs[i]);
      end
   endtask
   // Read/write returns the old bit and leaves the new one.
   task automatic t_rmw();
      logic q;
      access(MDC_OP_RMW, 14'h2A55, 1'b1, q);
      check(q, 1'b0);
      access(MDC_OP_READ, 14'h2A55, 1'b0, q);
      check(q, 1'b1);
   endtask
   // Idle long enough for every row to be refreshed by row-only cycles.
   task automatic t_refresh();
      int c;
      logic q;
      c = cas_falls;
      rows_hit = '0;
      repeat (128 * SPACING + 400) @(negedge core_clk);
      check(16'(&rows_hit), 16'h1);
      check(16'(cas_falls - c), 16'h0);
      access(MDC_OP_READ, 14'h3FFF, 1'b0, q);
      check(q, 1'b1);
   endtask
   initial begin
      repeat (10) @(posedge core_clk);
      resetn <= 1'b1;
      t_init();
      t_write_read();
      t_rmw();
      t_freeze();
      t_refresh();
      test_done();
   end
endmodule
bind mdc_ctrl mdc_ctrl_assertions #(.REF_SPACING(REF_SPACING)) chk (
   .core_clk  (core_clk),
   .resetn    (resetn),
   .req_ready (req_ready),
   .init_done (init_done),
   .mem       (mem)
);
